// ==== inc/mois_pkg.sv ====
`default_nettype none
package mois_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 10_000_000;
  localparam int TICK_MS = 100;
  localparam int TICK_CYCLES_DEF = CLK_HZ / 1000 * TICK_MS;
  localparam int TICK_W = 24;
  localparam int DEB_MS = 10;
  localparam int DEB_CYCLES_DEF = CLK_HZ / 1000 * DEB_MS;
  localparam int DEB_W = 20;
  // ----------------------------------------------------------------
  // Sizes and thermal format
  // ----------------------------------------------------------------
  localparam int NUM_DIN = 8;
  localparam int NUM_RLY = 6;
  localparam int CFG_W = 5;
  localparam int PCT_W = 7;
  localparam int FRAC_W = 16;
  localparam int CONT_W = PCT_W + FRAC_W;
  localparam int DIV_W = 17;
  localparam int HIST_N = 4;
  localparam int DLY_W = 10;
  localparam int COOL_W = 14;
  // ----------------------------------------------------------------
  // Values and limits
  // ----------------------------------------------------------------
  localparam logic [PCT_W-1:0] PCT_FULL = 7'h64;
  localparam logic [PCT_W-1:0] PCT_COLD = 7'h00;
  localparam logic [PCT_W-1:0] ALARM_DEF = 7'h5a;
  localparam logic [PCT_W-1:0] LOCK_DEF = 7'h0f;
  localparam logic [COOL_W-1:0] COOL_DEF = 14'h012c;
  localparam logic [COOL_W-1:0] COOL_MIN = 14'h000a;
  localparam logic [COOL_W-1:0] COOL_MAX = 14'h270f;
  localparam int SEC_PER_MIN = 60;
  localparam int DECAY_TCONST = 5;
  localparam int TAU_PER_COOL = SEC_PER_MIN / DECAY_TCONST;
  localparam int SAFETY_NUM = 5;
  localparam int SAFETY_SHIFT = 2;
  localparam logic [DLY_W-1:0] FDELAY_DEF = 10'h001;
  localparam logic [DLY_W-1:0] FDELAY_MIN = 10'h001;
  localparam logic [DLY_W-1:0] FDELAY_MAX = 10'h384;
  // ----------------------------------------------------------------
  // Input and relay functions
  // ----------------------------------------------------------------
  typedef enum logic [CFG_W-1:0] {
    DI_OFF = 5'h00, DI_STOP = 5'h01, DI_FAULT_HI = 5'h02,
    DI_FAULT_LO = 5'h03, DI_FAULT_RESET = 5'h04, DI_DISCONNECT = 5'h05,
    DI_INLINE_FB = 5'h06, DI_BYPASS_FB = 5'h07,
    DI_EMERG_CLEAR = 5'h08, DI_SRC_SELECT = 5'h09, DI_HEAT_DIS = 5'h0a,
    DI_HEAT_EN = 5'h0b, DI_RAMP2 = 5'h0c, DI_SLOW_FWD = 5'h0d,
    DI_SLOW_REV = 5'h0e, DI_BRAKE_DIS = 5'h0f, DI_BRAKE_EN = 5'h10,
    DI_ZS_OPEN = 5'h11, DI_ZS_CLOSED = 5'h12
  } mois_din_fn_t;
  typedef enum logic [CFG_W-1:0] {
    RF_OFF = 5'h00, RF_FAULT_RELAY_FAILSAFE = 5'h01, RF_FAULT_DIRECT = 5'h02,
    RF_RUNNING = 5'h03, RF_FULL_SPEED = 5'h04, RF_ALARM = 5'h05,
    RF_READY = 5'h06, RF_LOCKED = 5'h07, RF_OVERCURR = 5'h08,
    RF_UNDERCURR = 5'h09, RF_OL_WARN = 5'h0a, RF_TRIP_FS = 5'h0b,
    RF_TRIP_DIRECT = 5'h0c, RF_GROUND = 5'h0d, RF_SAVER = 5'h0e,
    RF_HEATING = 5'h0f, RF_SLOW = 5'h10, RF_SLOW_FWD = 5'h11,
    RF_SLOW_REV = 5'h12, RF_BRAKING = 5'h13, RF_FAN = 5'h14,
    RF_RIDE_THRU = 5'h15, RF_TACH_LOSS = 5'h16
  } mois_rly_fn_t;
  localparam logic [CFG_W-1:0] DIN1_CFG_DEF = 5'h01;
  localparam logic [CFG_W-1:0] DIN_CFG_DEF = 5'h00;
  localparam logic [CFG_W-1:0] RLY1_CFG_DEF = 5'h01;
  localparam logic [CFG_W-1:0] RLY_CFG_DEF = 5'h00;
  // ----------------------------------------------------------------
  // Cooling sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CS_IDLE = 3'b001, CS_DIVIDE = 3'b010, CS_APPLY = 3'b100
  } mois_cool_st_t;
endpackage : mois_pkg
`default_nettype wire

// ==== inc/mois_din_if.sv ====
`default_nettype none
interface mois_din_if;
  logic [7:0] raw;
  logic [7:0] clean;
  modport filter (input raw, output clean);
  modport user (output raw, input clean);
endinterface : mois_din_if
`default_nettype wire

// ==== src/mois_din_filter.sv ====
`default_nettype none
module mois_din_filter
  import mois_pkg::*;
#(
  parameter int DEB_CYCLES = DEB_CYCLES_DEF
) (
  input wire logic clock, // System clock.
  input wire logic rst_b, // Synchronous reset, active low.
  mois_din_if.filter din // Raw field inputs in, clean levels out.
);
  typedef struct packed {
    logic [NUM_DIN-1:0] sync1;
    logic [NUM_DIN-1:0] sync2;
    logic [NUM_DIN-1:0] stable;
    logic [NUM_DIN-1:0][DEB_W-1:0] cnt;
  } mois_deb_state_t;

  mois_deb_state_t s;
  mois_deb_state_t next_s;

  // A level is accepted only after it has held for the whole window,
  // so contact bounce never reaches the function decoding.
  always_comb begin
    next_s = s;
    next_s.sync1 = din.raw;
    next_s.sync2 = s.sync1;
    for (int i = 0; i < NUM_DIN; i++) begin
      if (s.sync2[i] == s.stable[i]) begin
        next_s.cnt[i] = '0;
      end else if (s.cnt[i] == DEB_W'(DEB_CYCLES - 1)) begin
        next_s.cnt[i] = '0;
        next_s.stable[i] = s.sync2[i];
      end else begin
        next_s.cnt[i] = s.cnt[i] + DEB_W'(1);
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign din.clean = s.stable;
endmodule : mois_din_filter
`default_nettype wire

// ==== src/mois_supervisor.sv ====
`default_nettype none
module mois_supervisor
  import mois_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DEF,
  parameter int DEB_CYCLES = DEB_CYCLES_DEF
) (
  input wire logic clock, // System clock, 10 MHz.
  input wire logic rst_b, // Synchronous reset, active low.
  input wire logic [NUM_DIN-1:0] din_raw, // Field input pins.
  input wire logic [NUM_DIN-1:0][CFG_W-1:0] din_cfg, // Input functions.
  input wire logic [DLY_W-1:0] fault_delay, // Fault delay, 0.1 s.
  input wire logic [COOL_W-1:0] cool_time, // Cooling time, 0.1 min.
  input wire logic [PCT_W-1:0] alarm_level, // Warning percent.
  input wire logic [PCT_W-1:0] thermal_lockout_level, // Fixed release.
  input wire logic learned_lockout_mode, // Learned release level.
  input wire logic [PCT_W-1:0] run_content, // Content while running.
  input wire logic overload_trip, // Thermal trip event.
  input wire logic motor_running, // Motor is running.
  input wire logic start_accept, // Start command taken, pulse.
  input wire logic at_full_speed, // Motor up to speed.
  input wire logic faulted, // Starter fault from elsewhere.
  input wire logic trip_coil_fault, // Shunt trip fault.
  input wire logic alarm_any, // Any alarm present.
  input wire logic ready, // Ready for start.
  input wire logic overcurrent, // Overcurrent alarm.
  input wire logic undercurrent, // Undercurrent alarm.
  input wire logic ground_fault, // Ground fault trip.
  input wire logic energy_saving, // Energy saver mode.
  input wire logic heating, // Heating pulses applied.
  input wire logic slow_speed, // Slow speed mode.
  input wire logic slow_fwd_active, // Slow speed forward.
  input wire logic slow_rev_active, // Slow speed reverse.
  input wire logic braking, // DC brake applied.
  input wire logic fan_on, // Heatsink fan demand.
  input wire logic ride_through, // Power outage ride-through.
  input wire logic tach_loss, // Tachometer loss fault.
  input wire logic [NUM_RLY-1:0][CFG_W-1:0] rly_cfg, // Relay functions.
  input wire logic [NUM_RLY-1:0] serial_relay, // Serial relay commands.
  output logic [NUM_RLY-1:0] relay, // Relay coils, high energised.
  output logic [PCT_W-1:0] overload_pct, // Content percent.
  output logic overload_warning, // Content at alarm level.
  output logic locked_out, // Restart blocked.
  output logic [PCT_W-1:0] release_level, // Active release percent.
  output logic starts_learned, // Four starts recorded.
  output logic input_fault, // Digital input fault latched.
  output logic stop_cmd, // Three-wire stop requested.
  output logic fault_reset_cmd, // Fault reset requested.
  output logic remote_select, // High remote, low local.
  output logic heat_disable, // Heating disabled.
  output logic heat_enable, // Heating enabled.
  output logic ramp2_select, // Second ramp selected.
  output logic slow_fwd_cmd, // Slow speed forward request.
  output logic slow_rev_cmd, // Slow speed reverse request.
  output logic brake_disable, // DC brake disabled.
  output logic brake_enable, // DC brake enabled.
  output logic disconnect_closed, // Disconnect monitor.
  output logic inline_feedback, // Inline contactor feedback.
  output logic bypass_feedback, // Bypass contactor feedback.
  output logic zero_speed // Zero speed from switch.
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [CONT_W-1:0] content;
    mois_cool_st_t cst;
    logic [CONT_W-1:0] quo;
    logic [DIV_W:0] rem;
    logic [4:0] bitn;
    logic [TICK_W-1:0] tick_cnt;
    logic locked;
    logic start_pend;
    logic [PCT_W-1:0] start_pct;
    logic [HIST_N-1:0][PCT_W-1:0] hist;
    logic [2:0] hist_n;
    logic speed_d;
    logic run_d;
    logic [NUM_DIN-1:0][DLY_W-1:0] fcnt;
    logic in_fault;
    logic warn;
    logic [NUM_RLY-1:0] relay;
    logic [14:0] cmd;
  } mois_sup_state_t;

  mois_sup_state_t s;
  mois_sup_state_t next_s;
  mois_din_if din ();
  logic [NUM_DIN-1:0] clean;

  // ----------------------------------------------------------------
  // Input conditioning
  // ----------------------------------------------------------------
  assign din.raw = din_raw;
  assign clean = din.clean;

  mois_din_filter #(
    .DEB_CYCLES(DEB_CYCLES)
  ) u_filter (
    .clock(clock),
    .rst_b(rst_b),
    .din(din)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic tick;
  logic [PCT_W-1:0] pct;
  logic [PCT_W-1:0] pct_run;
  logic [COOL_W-1:0] cool_c;
  logic [DIV_W-1:0] divisor;
  logic [DIV_W:0] rem_sh;
  logic [9:0] hsum;
  logic [PCT_W-1:0] avg;
  logic [9:0] scaled;
  logic [PCT_W-1:0] rel;
  logic [PCT_W-1:0] used;
  logic [DLY_W-1:0] dly;
  logic [14:0] fn;
  logic stop_open;
  logic zs;
  logic fault_cond;
  logic emerg;
  logic fault_set;
  logic flt;
  mois_din_fn_t dfn;
  mois_rly_fn_t rfn;

  // Decay, lockout, start learning, input and relay mapping.
  always_comb begin
    next_s = s;
    tick = (s.tick_cnt == TICK_W'(TICK_CYCLES - 1));
    next_s.tick_cnt = tick ? '0 : s.tick_cnt + TICK_W'(1);
    pct = s.content[CONT_W-1:FRAC_W];
    pct_run = (run_content > PCT_FULL) ? PCT_FULL : run_content;
    // Out-of-range settings are clamped, so the divisor never is zero.
    cool_c = cool_time;
    if (cool_c < COOL_MIN) begin
      cool_c = COOL_MIN;
    end else if (cool_c > COOL_MAX) begin
      cool_c = COOL_MAX;
    end
    // Tau in ticks: tenths of a minute times 60, over 5.
    divisor = DIV_W'(cool_c) * DIV_W'(TAU_PER_COOL);
    rem_sh = {s.rem[DIV_W-1:0], s.quo[CONT_W-1]};

    // Learned release: 100 minus integer average times 1.25.
    hsum = '0;
    for (int k = 0; k < HIST_N; k++) begin
      hsum = hsum + 10'(s.hist[k]);
    end
    avg = PCT_W'(hsum >> 2);
    scaled = 10'((10'(avg) * 10'(SAFETY_NUM)) >> SAFETY_SHIFT);
    if (learned_lockout_mode && s.hist_n == 3'(HIST_N)) begin
      rel = (scaled >= 10'(PCT_FULL)) ? PCT_COLD
          : PCT_W'(10'(PCT_FULL) - scaled);
    end else begin
      rel = thermal_lockout_level;
    end

    // Input functions, ORed where several inputs share one.
    fn = '0;
    stop_open = 1'b0;
    zs = 1'b0;
    fault_set = 1'b0;
    dly = (fault_delay < FDELAY_MIN) ? FDELAY_MIN : fault_delay;
    dly = (dly > FDELAY_MAX) ? FDELAY_MAX : dly;
    for (int i = 0; i < NUM_DIN; i++) begin
      dfn = mois_din_fn_t'(din_cfg[i]);
      fault_cond = 1'b0;
      case (dfn)
        DI_STOP: stop_open = stop_open | ~clean[i];
        DI_FAULT_HI: fault_cond = clean[i];
        DI_FAULT_LO: fault_cond = ~clean[i];
        DI_FAULT_RESET: fn[0] = fn[0] | clean[i];
        DI_EMERG_CLEAR: fn[1] = fn[1] | clean[i];
        DI_SRC_SELECT: fn[2] = fn[2] | clean[i];
        DI_HEAT_DIS: fn[3] = fn[3] | clean[i];
        DI_HEAT_EN: fn[4] = fn[4] | clean[i];
        DI_RAMP2: fn[5] = fn[5] | clean[i];
        DI_SLOW_FWD: fn[6] = fn[6] | clean[i];
        DI_SLOW_REV: fn[7] = fn[7] | clean[i];
        DI_BRAKE_DIS: fn[8] = fn[8] | clean[i];
        DI_BRAKE_EN: fn[9] = fn[9] | clean[i];
        DI_DISCONNECT: fn[10] = fn[10] | clean[i];
        DI_INLINE_FB: fn[11] = fn[11] | clean[i];
        DI_BYPASS_FB: fn[12] = fn[12] | clean[i];
        DI_ZS_OPEN: zs = zs | ~clean[i];
        DI_ZS_CLOSED: zs = zs | clean[i];
        default: fault_cond = 1'b0;
      endcase
      // The delay counts whole ticks of the condition, nothing else.
      if (!fault_cond) begin
        next_s.fcnt[i] = '0;
      end else if (s.fcnt[i] >= dly) begin
        fault_set = 1'b1;
      end else if (tick) begin
        next_s.fcnt[i] = s.fcnt[i] + DLY_W'(1);
      end
    end
    fn[13] = stop_open;
    fn[14] = zs;
    next_s.cmd = fn;
    // A new fault wins over a reset arriving in the same cycle.
    if (fault_set) begin
      next_s.in_fault = 1'b1;
    end else if (fn[0]) begin
      next_s.in_fault = 1'b0;
    end

    // Emergency clear acts only while the lockout is set, by a trip or by full content.
    emerg = fn[1] && s.locked;
    if (emerg) begin
      next_s.content = '0;
      next_s.cst = CS_IDLE;
    end else if (motor_running) begin
      next_s.content = {pct_run, FRAC_W'(0)};
      next_s.cst = CS_IDLE;
    end else begin
      // One serial division per tick gives content*dt/tau.
      case (s.cst)
        CS_IDLE: begin
          if (tick && s.content != '0) begin
            next_s.quo = s.content;
            next_s.rem = '0;
            next_s.bitn = 5'(CONT_W - 1);
            next_s.cst = CS_DIVIDE;
          end
        end
        CS_DIVIDE: begin
          if (rem_sh >= {1'b0, divisor}) begin
            next_s.rem = rem_sh - {1'b0, divisor};
            next_s.quo = {s.quo[CONT_W-2:0], 1'b1};
          end else begin
            next_s.rem = rem_sh;
            next_s.quo = {s.quo[CONT_W-2:0], 1'b0};
          end
          if (s.bitn == '0) begin
            next_s.cst = CS_APPLY;
          end else begin
            next_s.bitn = s.bitn - 5'(1);
          end
        end
        CS_APPLY: begin
          // A zero step still moves one count so the tail reaches 0.
          if (s.quo == '0) begin
            next_s.content = s.content - CONT_W'(1);
          end else begin
            next_s.content = s.content - s.quo;
          end
          next_s.cst = CS_IDLE;
        end
        default: next_s.cst = CS_IDLE;
      endcase
    end

    // Trip sets the lockout and wins over the release.
    if (overload_trip || pct >= PCT_FULL) begin
      next_s.locked = 1'b1;
    end else if (emerg || pct < rel) begin
      next_s.locked = 1'b0;
    end
    next_s.warn = (pct >= alarm_level);

    // Start learning: latch at start, record at full speed.
    next_s.speed_d = at_full_speed;
    next_s.run_d = motor_running;
    used = (pct > s.start_pct) ? pct - s.start_pct : PCT_COLD;
    if (start_accept) begin
      next_s.start_pend = 1'b1;
      next_s.start_pct = pct;
    end else if (s.start_pend && at_full_speed && !s.speed_d) begin
      next_s.start_pend = 1'b0;
      next_s.hist = {s.hist[HIST_N-2:0], used};
      if (s.hist_n != 3'(HIST_N)) begin
        next_s.hist_n = s.hist_n + 3'(1);
      end
    end else if (s.start_pend && s.run_d && !motor_running) begin
      next_s.start_pend = 1'b0;
    end

    // Relay mapping; faulted also covers a latched input fault.
    flt = faulted | s.in_fault;
    for (int r = 0; r < NUM_RLY; r++) begin
      rfn = mois_rly_fn_t'(rly_cfg[r]);
      case (rfn)
        RF_OFF: next_s.relay[r] = serial_relay[r];
        RF_FAULT_RELAY_FAILSAFE: next_s.relay[r] = ~flt;
        RF_FAULT_DIRECT: next_s.relay[r] = flt;
        RF_TRIP_FS: next_s.relay[r] = ~trip_coil_fault;
        RF_TRIP_DIRECT: next_s.relay[r] = trip_coil_fault;
        RF_RUNNING: next_s.relay[r] = motor_running;
        RF_FULL_SPEED: next_s.relay[r] = at_full_speed;
        RF_ALARM: next_s.relay[r] = alarm_any;
        RF_READY: next_s.relay[r] = ready;
        RF_LOCKED: next_s.relay[r] = s.locked;
        RF_OVERCURR: next_s.relay[r] = overcurrent;
        RF_UNDERCURR: next_s.relay[r] = undercurrent;
        RF_OL_WARN: next_s.relay[r] = s.warn;
        RF_GROUND: next_s.relay[r] = ground_fault;
        RF_SAVER: next_s.relay[r] = energy_saving;
        RF_HEATING: next_s.relay[r] = heating;
        RF_SLOW: next_s.relay[r] = slow_speed;
        RF_SLOW_FWD: next_s.relay[r] = slow_fwd_active;
        RF_SLOW_REV: next_s.relay[r] = slow_rev_active;
        RF_BRAKING: next_s.relay[r] = braking;
        RF_FAN: next_s.relay[r] = fan_on;
        RF_RIDE_THRU: next_s.relay[r] = ride_through;
        RF_TACH_LOSS: next_s.relay[r] = tach_loss;
        default: next_s.relay[r] = 1'b0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Reset starts cold and idle; relays open until the first mapping.
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      s <= '0;
      s.cst <= CS_IDLE;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign relay = s.relay;
  assign overload_pct = s.content[CONT_W-1:FRAC_W];
  assign overload_warning = s.warn;
  assign locked_out = s.locked;
  assign release_level = rel;
  assign starts_learned = (s.hist_n == 3'(HIST_N));
  assign input_fault = s.in_fault;
  assign fault_reset_cmd = s.cmd[0];
  assign remote_select = s.cmd[2];
  assign heat_disable = s.cmd[3];
  assign heat_enable = s.cmd[4];
  assign ramp2_select = s.cmd[5];
  assign slow_fwd_cmd = s.cmd[6];
  assign slow_rev_cmd = s.cmd[7];
  assign brake_disable = s.cmd[8];
  assign brake_enable = s.cmd[9];
  assign disconnect_closed = s.cmd[10];
  assign inline_feedback = s.cmd[11];
  assign bypass_feedback = s.cmd[12];
  assign stop_cmd = s.cmd[13];
  assign zero_speed = s.cmd[14];
endmodule : mois_supervisor
`default_nettype wire

// ==== test/mois_field_model.sv ====
`default_nettype none
module mois_field_model (
  input wire logic clock, // System clock.
  input wire logic [7:0] sw, // Wanted contact states.
  output logic [7:0] din_raw // Field input pins.
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] l1 = 8'h00;
  logic [7:0] l2 = 8'h00;
  // A moved contact shows new, old, new: a bounce the filter must hide.
  always @(posedge clock) begin
    l1 <= sw;
    l2 <= l1;
    din_raw <= sw ^ l1 ^ l2;
  end
endmodule : mois_field_model
`default_nettype wire

// ==== test/mois_supervisor_chk.sv ====
`default_nettype none
module mois_supervisor_chk import mois_pkg::*; (
  input wire logic clock, rst_b, // Clock and reset.
  input wire logic [NUM_RLY-1:0][CFG_W-1:0] rly_cfg, // Relay functions.
  input wire logic [NUM_RLY-1:0] relay, serial_relay, // Coils, commands.
  input wire logic faulted, trip_coil_fault, overload_trip, // Causes.
  input wire logic motor_running, locked_out, overload_warning, // State.
  input wire logic starts_learned, // History full.
  input wire logic [PCT_W-1:0] overload_pct, alarm_level, // Content.
  input wire logic [PCT_W-1:0] release_level, thermal_lockout_level // Levels.
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);
  // Two quiet cycles first, so a registered compare has caught up.
  property p_warn;
    ($stable(overload_pct) && $stable(alarm_level))[*2]
      |-> overload_warning == (overload_pct >= alarm_level);
  endproperty
  a_warn: assert property (p_warn) else $error("warning level");
  property p_fs;
    rly_cfg[0] == RF_FAULT_RELAY_FAILSAFE && faulted |=> !relay[0];
  endproperty
  a_fs: assert property (p_fs) else $error("failsafe relay");
  property p_direct;
    rly_cfg[1] == RF_FAULT_DIRECT && faulted |=> relay[1];
  endproperty
  a_direct: assert property (p_direct) else $error("direct relay");
  property p_trip;
    rly_cfg[2] == RF_TRIP_FS |=> relay[2] != $past(trip_coil_fault);
  endproperty
  a_trip: assert property (p_trip) else $error("trip coil relay");
  property p_free;
    rly_cfg[3] == RF_OFF |=> relay[3] == $past(serial_relay[3]);
  endproperty
  a_free: assert property (p_free) else $error("serial relay");
  property p_lock;
    overload_trip |=> locked_out;
  endproperty
  a_lock: assert property (p_lock) else $error("no lockout");
  property p_fallback;
    !starts_learned |-> release_level == thermal_lockout_level;
  endproperty
  a_fallback: assert property (p_fallback) else $error("release");
  property p_cap;
    overload_pct <= PCT_FULL;
  endproperty
  a_cap: assert property (p_cap) else $error("content above full");
  property p_cool;
    !motor_running && !$past(motor_running)
      |=> overload_pct <= $past(overload_pct);
  endproperty
  a_cool: assert property (p_cool) else $error("rise while stopped");
  c_warn: cover property (overload_warning);
  c_unlock: cover property ($fell(locked_out));
  c_learn: cover property (starts_learned);
endmodule : mois_supervisor_chk
bind mois_supervisor mois_supervisor_chk u_chk (.*);
`default_nettype wire

// ==== test/mois_supervisor_tb_top.sv ====
`default_nettype none
module mois_supervisor_tb_top import mois_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0, rst_b = 1'b0;
  logic [7:0] sw = 8'h00, din_raw;
  logic [NUM_DIN-1:0][CFG_W-1:0] din_cfg = {{7{5'h00}}, 5'h01};
  logic [DLY_W-1:0] fault_delay = 10'h003;
  logic [COOL_W-1:0] cool_time = 14'h000a;
  logic [PCT_W-1:0] alarm_level = 7'h5a, thermal_lockout_level = 7'h0f;
  logic [PCT_W-1:0] run_content = 7'h00, overload_pct, release_level;
  logic learned_lockout_mode = 1'b0, overload_trip = 1'b0;
  logic motor_running = 1'b0, start_accept = 1'b0, at_full_speed = 1'b0;
  logic faulted = 1'b0, trip_coil_fault = 1'b0, alarm_any = 1'b0;
  logic ready = 1'b0, overcurrent = 1'b0, undercurrent = 1'b0;
  logic ground_fault = 1'b0, energy_saving = 1'b0, heating = 1'b0;
  logic slow_speed = 1'b0, slow_fwd_active = 1'b0, slow_rev_active = 1'b0;
  logic braking = 1'b0, fan_on = 1'b0, ride_through = 1'b0;
  logic tach_loss = 1'b0;
  logic [NUM_RLY-1:0][CFG_W-1:0] rly_cfg = {{5{5'h00}}, 5'h01};
  logic [NUM_RLY-1:0] serial_relay = 6'h00, relay;
  logic overload_warning, locked_out, starts_learned, input_fault;
  logic stop_cmd, fault_reset_cmd, remote_select, heat_disable, heat_enable;
  logic ramp2_select, slow_fwd_cmd, slow_rev_cmd, brake_disable;
  logic brake_enable, disconnect_closed, inline_feedback, bypass_feedback;
  logic zero_speed;
  int miscompares = 0, samples_checked = 0, budget = 0;
  // A tick of 25 cycles still leaves room for the 24-cycle decay step.
  mois_supervisor #(.TICK_CYCLES(25), .DEB_CYCLES(4)) DUT (.*);
  mois_field_model FIELD (.clock(clock), .sw(sw), .din_raw(din_raw));
  always #50 clock = ~clock;
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : step
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic print_verdict();
    $display("checked %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : print_verdict
  // Waits for the content to fall to a level, within the shared budget.
  task automatic wait_pct(input logic [PCT_W-1:0] lvl);
    while (overload_pct > lvl && budget > 0) begin
      step(1);
      budget--;
    end
    if (budget == 0) begin
      miscompares++;
      print_verdict();
    end
  endtask : wait_pct
  // A stop pulse shorter than the filter window must not get through.
  task automatic scn_reset();
    rst_b = 1'b1;
    step(12);
    check({relay[0], stop_cmd}, 8'h03);
    sw[0] = 1'b1;
    step(12);
    sw[0] = 1'b0;
    step(2);
    sw[0] = 1'b1;
    for (int i = 0; i < 12; i++) begin
      step(1);
      check(stop_cmd, 8'h00);
    end
  endtask : scn_reset
  task automatic scn_relays();
    logic e;
    serial_relay = 6'h2a;
    for (int v = 1; v >= 0; v--) begin
      {faulted, trip_coil_fault, alarm_any, ready, overcurrent, undercurrent,
        ground_fault, energy_saving, heating, slow_speed, slow_fwd_active,
        slow_rev_active, braking, fan_on, ride_through, tach_loss,
        motor_running, at_full_speed} = {18{v[0]}};
      for (int c = 0; c < 23; c++) begin
        rly_cfg = {6{c[4:0]}};
        step(2);
        e = (c == RF_LOCKED || c == RF_OL_WARN) ? 1'b0 :
          v[0] ^ (c == RF_FAULT_RELAY_FAILSAFE || c == RF_TRIP_FS);
        check(relay, c == 0 ? serial_relay : {6{e}});
      end
    end
  endtask : scn_relays
  task automatic scn_fault();
    din_cfg[2] = DI_FAULT_RESET;
    for (int i = 0; i < 2; i++) begin
      din_cfg[1] = (i != 0) ? DI_FAULT_LO : DI_FAULT_HI;
      sw[1] = (i == 0);
      step(40);
      check(input_fault, 8'h00);
      step(60);
      check(input_fault, 8'h01);
      sw[1] = (i != 0);
      sw[2] = 1'b1;
      step(12);
      check({fault_reset_cmd, input_fault}, 8'h02);
      sw[2] = 1'b0;
      step(12);
    end
    din_cfg[1] = DI_OFF;
  endtask : scn_fault
  task automatic scn_decode();
    mois_din_fn_t fn[12] = '{DI_SRC_SELECT, DI_HEAT_DIS, DI_HEAT_EN,
      DI_RAMP2, DI_ZS_CLOSED, DI_SLOW_FWD, DI_SLOW_REV, DI_BRAKE_DIS,
      DI_BRAKE_EN, DI_DISCONNECT, DI_INLINE_FB, DI_BYPASS_FB};
    sw[3] = 1'b1;
    for (int i = 0; i < 13; i++) begin
      din_cfg[3] = (i < 12) ? fn[i] : DI_ZS_OPEN;
      sw[3] = (i < 12);
      step(10);
      check({remote_select, heat_disable, heat_enable, ramp2_select,
        zero_speed}, (i < 5) ? 8'h10 >> i : 8'(i == 12));
      check({slow_fwd_cmd, slow_rev_cmd, brake_disable, brake_enable,
        disconnect_closed, inline_feedback, bypass_feedback},
        (i < 5 || i == 12) ? 8'h00 : 8'h40 >> (i - 5));
    end
  endtask : scn_decode
  task automatic scn_thermal();
    motor_running = 1'b1;
    for (int i = 0; i < 3; i++) begin
      run_content = 7'h59 + i[6:0];
      step(4);
      check({overload_warning, overload_pct}, {i != 0, run_content});
    end
    run_content = 7'h7f;
    step(4);
    check({locked_out, overload_pct}, 8'he4);
    motor_running = 1'b0;
    budget = 15000; // One cooling time: 600 ticks of 25 cycles.
    wait_pct(7'h20);
    check(locked_out, 8'h01);
    wait_pct(7'h0e);
    step(2);
    check(locked_out, 8'h00);
    wait_pct(7'h00);
    motor_running = 1'b1;
    overload_trip = 1'b1;
    step(2);
    motor_running = 1'b0;
    overload_trip = 1'b0;
    din_cfg[4] = DI_EMERG_CLEAR;
    sw[4] = 1'b1;
    step(12);
    check({locked_out, overload_pct}, 8'h00);
    sw[4] = 1'b0;
  endtask : scn_thermal
  // The third start is aborted, so it must leave no trace in the history.
  task automatic scn_learn();
    logic [6:0] d[5] = '{7'h1e, 7'h1d, 7'h32, 7'h1e, 7'h1b};
    learned_lockout_mode = 1'b1;
    for (int i = 0; i < 5; i++) begin
      run_content = 7'h0a;
      motor_running = 1'b1;
      step(3);
      start_accept = 1'b1;
      step(1);
      start_accept = 1'b0;
      run_content = 7'h0a + d[i];
      step(3);
      at_full_speed = (i != 2);
      step(2);
      at_full_speed = 1'b0;
      motor_running = 1'b0;
      step(2);
      if (i == 3) check({starts_learned, release_level}, 8'h0f);
    end
    check({starts_learned, release_level}, 8'hc0);
  endtask : scn_learn
  initial begin
    step(16);
    check({relay, locked_out}, 8'h00);
    scn_reset();
    scn_relays();
    scn_fault();
    scn_decode();
    scn_thermal();
    scn_learn();
    print_verdict();
  end
endmodule : mois_supervisor_tb_top
`default_nettype wire
